// *** hw/coordinate_store_and_accu_immediate_cmd_a.sv ***
`timescale 1ns/1ps
`default_nettype none
module coordinate_store_and_accu_immediate_cmd_a
  import coord_immediate_cmd_a_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host frame bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] module_addr,
  // stored program command
  input wire logic prog_valid,
  input wire logic [7:0] prog_opcode,
  input wire logic [7:0] prog_type,
  input wire logic [7:0] prog_motor,
  input wire logic [31:0] prog_value,
  // system inputs
  input wire logic coord_nv_mode,
  input wire logic [NUM_MOTORS-1:0][31:0] actual_pos,
  // reply
  output logic busy,
  output logic reply_valid,
  output logic reply_prog,
  output logic [7:0] reply_status,
  output logic [7:0] reply_opcode,
  output logic [31:0] reply_value,
  // axis parameter write
  output logic param_wr,
  output logic [1:0] param_motor,
  output logic [7:0] param_num,
  output logic [31:0] param_data,
  // register view
  output logic [31:0] accu_out
);
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_EXEC, ST_DIV, ST_COPY} state_type;

  typedef struct packed {
    state_type state;
    logic [3:0] byte_cnt;
    logic [7:0] sum;
    logic [7:0] addr;
    logic [7:0] op;
    logic [7:0] typ;
    logic [7:0] mot;
    logic [31:0] val;
    logic from_prog;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [1:0] copy_mot;
    logic [4:0] copy_idx;
    logic copy_single;
    logic copy_quiet;
    logic busy;
    logic reply_valid;
    logic reply_prog;
    logic [7:0] reply_status;
    logic [7:0] reply_opcode;
    logic [31:0] reply_value;
    logic param_wr;
    logic [1:0] param_motor;
    logic [7:0] param_num;
    logic [31:0] param_data;
  } ctrl_type;

  ctrl_type s_reg, s_next;

  // coordinate tables: working RAM and nonvolatile copy
  logic [31:0] coord_ram [NUM_MOTORS][NUM_COORDS];
  logic [31:0] coord_nv [NUM_MOTORS][NUM_COORDS];
  logic ram_we, nv_we;
  logic [1:0] wr_mot;
  logic [4:0] wr_idx;
  logic [31:0] wr_data;

  // divider hookup
  logic div_start, div_done;
  logic [31:0] div_quo, div_rem;
  logic [63:0] product;
  logic idx_ok, mot_ok;
  logic [31:0] rd_data;

  signed_divider u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(div_start),
    .dividend(s_reg.accu),
    .divisor(s_reg.xreg),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  assign product = s_reg.accu * s_reg.xreg;
  assign idx_ok = (s_reg.typ <= COORD_MAX);
  assign mot_ok = (s_reg.mot <= MOTOR_MAX);
  assign rd_data = coord_ram[s_reg.mot[1:0]][s_reg.typ[4:0]];

  // command reception, execution and copy sequencing
  always_comb begin
    s_next = s_reg;
    s_next.reply_valid = 1'b0;
    s_next.param_wr = 1'b0;
    ram_we = 1'b0;
    nv_we = 1'b0;
    wr_mot = s_reg.mot[1:0];
    wr_idx = s_reg.typ[4:0];
    wr_data = WORD_RESET;
    div_start = 1'b0;
    s_next.reply_prog = s_reg.from_prog;
    s_next.reply_opcode = s_reg.op;
    case (s_reg.state)
      ST_BOOT: begin
        // startup reload only when nonvolatile storage is selected
        s_next.copy_mot = 2'h0;
        s_next.copy_idx = 5'h01;
        s_next.copy_single = 1'b0;
        s_next.copy_quiet = 1'b1;
        s_next.state = coord_nv_mode ? ST_COPY : ST_IDLE;
        s_next.busy = coord_nv_mode;
      end
      ST_IDLE: begin
        if (prog_valid) begin
          s_next.op = prog_opcode;
          s_next.typ = prog_type;
          s_next.mot = prog_motor;
          s_next.val = prog_value;
          s_next.from_prog = 1'b1;
          s_next.busy = 1'b1;
          s_next.state = ST_EXEC;
        end else if (rx_valid) begin
          // frame fields in order, value most significant first
          case (s_reg.byte_cnt)
            4'h0: s_next.addr = rx_byte;
            4'h1: s_next.op = rx_byte;
            4'h2: s_next.typ = rx_byte;
            4'h3: s_next.mot = rx_byte;
            default: s_next.val = {s_reg.val[23:0], rx_byte};
          endcase
          s_next.sum = 8'(s_reg.sum + rx_byte);
          s_next.byte_cnt = 4'(s_reg.byte_cnt + 4'h1);
          if (s_reg.byte_cnt == FRAME_CSUM_POS) begin
            s_next.val = s_reg.val;
            s_next.byte_cnt = 4'h0;
            s_next.sum = 8'h00;
            s_next.from_prog = 1'b0;
            if (s_reg.addr != module_addr) begin
              s_next.state = ST_IDLE;
            end else if (rx_byte != s_reg.sum) begin
              s_next.reply_valid = 1'b1;
              s_next.reply_prog = 1'b0;
              s_next.reply_status = STATUS_BAD_CSUM;
              s_next.reply_value = WORD_RESET;
            end else begin
              s_next.busy = 1'b1;
              s_next.state = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        s_next.state = ST_IDLE;
        s_next.busy = 1'b0;
        s_next.reply_valid = 1'b1;
        s_next.reply_status = STATUS_OK;
        s_next.reply_value = WORD_RESET;
        case (s_reg.op)
          OP_COORD_READ: begin
            if (s_reg.mot == RESTORE_MOTOR) begin
              s_next.copy_quiet = 1'b0;
              s_next.copy_mot = 2'h0;
              if (s_reg.typ == 8'h00) begin
                s_next.copy_idx = 5'h01;
                s_next.copy_single = 1'b0;
                s_next.reply_valid = 1'b0;
                s_next.busy = 1'b1;
                s_next.state = ST_COPY;
              end else if (idx_ok) begin
                s_next.copy_idx = s_reg.typ[4:0];
                s_next.copy_single = 1'b1;
                s_next.reply_valid = 1'b0;
                s_next.busy = 1'b1;
                s_next.state = ST_COPY;
              end else begin
                s_next.reply_status = STATUS_BAD_TYPE;
              end
            end else if (!mot_ok) begin
              s_next.reply_status = STATUS_BAD_VALUE;
            end else if (!idx_ok) begin
              s_next.reply_status = STATUS_BAD_TYPE;
            end else begin
              s_next.reply_value = rd_data;
              if (s_reg.from_prog) s_next.accu = rd_data;
            end
          end
          OP_POS_CAPTURE, OP_ACCU_COORD: begin
            if (!mot_ok) begin
              s_next.reply_status = STATUS_BAD_VALUE;
            end else if (!idx_ok) begin
              s_next.reply_status = STATUS_BAD_TYPE;
            end else begin
              ram_we = 1'b1;
              nv_we = coord_nv_mode && (s_reg.typ != 8'h00);
              if (s_reg.op == OP_POS_CAPTURE) begin
                wr_data = actual_pos[s_reg.mot[1:0]];
                s_next.reply_value = wr_data;
              end else begin
                wr_data = s_reg.accu;
              end
            end
          end
          OP_ACCU_AXIS: begin
            if (!mot_ok) begin
              s_next.reply_status = STATUS_BAD_VALUE;
            end else begin
              s_next.param_wr = 1'b1;
              s_next.param_motor = s_reg.mot[1:0];
              s_next.param_num = s_reg.typ;
              s_next.param_data = s_reg.accu;
            end
          end
          OP_X_IMMEDIATE_CMD_A: begin
            // accumulator is first operand, X second; result to accumulator, to X for types 8 and 9, to both for type 10
            case (s_reg.typ)
              IMMEDIATE_CMD_A_ADD: s_next.accu = 32'(s_reg.accu + s_reg.xreg);
              IMMEDIATE_CMD_A_SUB: s_next.accu = 32'(s_reg.accu - s_reg.xreg);
              IMMEDIATE_CMD_A_MUL: s_next.accu = product[31:0];
              IMMEDIATE_CMD_A_DIV, IMMEDIATE_CMD_A_MOD: begin
                if (s_reg.xreg == WORD_RESET) begin
                  s_next.reply_status = STATUS_BAD_VALUE;
                end else begin
                  div_start = 1'b1;
                  s_next.reply_valid = 1'b0;
                  s_next.busy = 1'b1;
                  s_next.state = ST_DIV;
                end
              end
              IMMEDIATE_CMD_A_AND: s_next.accu = s_reg.accu & s_reg.xreg;
              IMMEDIATE_CMD_A_OR: s_next.accu = s_reg.accu | s_reg.xreg;
              IMMEDIATE_CMD_A_XOR: s_next.accu = s_reg.accu ^ s_reg.xreg;
              IMMEDIATE_CMD_A_NOT: s_next.xreg = ~s_reg.xreg;
              IMMEDIATE_CMD_A_LOAD: s_next.xreg = s_reg.accu;
              IMMEDIATE_CMD_A_SWAP: begin
                s_next.accu = s_reg.xreg;
                s_next.xreg = s_reg.accu;
              end
              default: s_next.reply_status = STATUS_BAD_TYPE;
            endcase
          end
          default: s_next.reply_status = STATUS_BAD_CMD;
        endcase
      end
      ST_DIV: begin
        if (div_done) begin
          s_next.accu = (s_reg.typ == IMMEDIATE_CMD_A_DIV) ? div_quo : div_rem;
          s_next.reply_valid = 1'b1;
          s_next.reply_status = STATUS_OK;
          s_next.reply_value = WORD_RESET;
          s_next.busy = 1'b0;
          s_next.state = ST_IDLE;
        end
      end
      ST_COPY: begin
        // one entry per cycle from nonvolatile copy into RAM, entry 0 skipped
        ram_we = 1'b1;
        wr_mot = s_reg.copy_mot;
        wr_idx = s_reg.copy_idx;
        wr_data = coord_nv[s_reg.copy_mot][s_reg.copy_idx];
        s_next.copy_mot = 2'(s_reg.copy_mot + 2'h1);
        if (s_reg.copy_mot == MOTOR_MAX[1:0]) begin
          if (s_reg.copy_single || s_reg.copy_idx == COORD_MAX[4:0]) begin
            s_next.state = ST_IDLE;
            s_next.busy = 1'b0;
            s_next.reply_valid = !s_reg.copy_quiet;
            s_next.reply_status = STATUS_OK;
            s_next.reply_value = WORD_RESET;
          end else begin
            s_next.copy_idx = 5'(s_reg.copy_idx + 5'h01);
          end
        end
      end
      default: s_next.state = ST_IDLE;
    endcase
  end

  // control state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // coordinate memories, not reset
  always_ff @(posedge sys_clk) begin
    if (ram_we) coord_ram[wr_mot][wr_idx] <= wr_data;
    if (nv_we) coord_nv[wr_mot][wr_idx] <= wr_data;
  end

  // outputs straight from the state register
  assign busy = s_reg.busy;
  assign reply_valid = s_reg.reply_valid;
  assign reply_prog = s_reg.reply_prog;
  assign reply_status = s_reg.reply_status;
  assign reply_opcode = s_reg.reply_opcode;
  assign reply_value = s_reg.reply_value;
  assign param_wr = s_reg.param_wr;
  assign param_motor = s_reg.param_motor;
  assign param_num = s_reg.param_num;
  assign param_data = s_reg.param_data;
  assign accu_out = s_reg.accu;
endmodule : coordinate_store_and_accu_immediate_cmd_a
`default_nettype wire

// *** common/coord_immediate_cmd_a_pkg.sv ***
// Functional notes
// - index 0, motor 255: restore all from nonvolatile
// - motor 255, index 1..20: restore one entry
// - capture: store motor actual position in entry
// - setting 84 selects RAM only or nonvolatile
// - entry 0 never saved nor restored
// - capture replies 100 with captured value
// - accumulator to coordinate stores accumulator in entry
// - x immediate_cmd_a: accumulator op X into accumulator for types 0..7
// - types 0..4: add sub mul div mod
// - types 5..7: and or xor
// - type 8 inverts X register
// - type 9 copies accumulator into X
// - type 10 swaps accumulator and X
// - accu to axis parameter writes addressed parameter
// - nine-byte frame, value most significant first
// - read: host gets reply, program loads accumulator
// - 21 coordinate entries (0..20) per axis
package coord_immediate_cmd_a_pkg;
  // command opcodes
  localparam logic [7:0] OP_COORD_READ = 8'h1F;
  localparam logic [7:0] OP_POS_CAPTURE = 8'h20;
  localparam logic [7:0] OP_X_IMMEDIATE_CMD_A = 8'h21;
  localparam logic [7:0] OP_ACCU_AXIS = 8'h22;
  localparam logic [7:0] OP_ACCU_COORD = 8'h27;
  // special motor field for nonvolatile restore forms
  localparam logic [7:0] RESTORE_MOTOR = 8'hFF;
  // table geometry
  localparam int NUM_MOTORS = 4;
  localparam int NUM_COORDS = 21;
  localparam logic [7:0] MOTOR_MAX = 8'h03;
  localparam logic [7:0] COORD_MAX = 8'h14;
  // frame layout: byte position of checksum
  localparam logic [3:0] FRAME_CSUM_POS = 4'h8;
  // reply status codes
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  // x register calculate types
  localparam logic [7:0] IMMEDIATE_CMD_A_ADD = 8'h00;
  localparam logic [7:0] IMMEDIATE_CMD_A_SUB = 8'h01;
  localparam logic [7:0] IMMEDIATE_CMD_A_MUL = 8'h02;
  localparam logic [7:0] IMMEDIATE_CMD_A_DIV = 8'h03;
  localparam logic [7:0] IMMEDIATE_CMD_A_MOD = 8'h04;
  localparam logic [7:0] IMMEDIATE_CMD_A_AND = 8'h05;
  localparam logic [7:0] IMMEDIATE_CMD_A_OR = 8'h06;
  localparam logic [7:0] IMMEDIATE_CMD_A_XOR = 8'h07;
  localparam logic [7:0] IMMEDIATE_CMD_A_NOT = 8'h08;
  localparam logic [7:0] IMMEDIATE_CMD_A_LOAD = 8'h09;
  localparam logic [7:0] IMMEDIATE_CMD_A_SWAP = 8'h0A;
  // divider steps
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
endpackage : coord_immediate_cmd_a_pkg

// *** hw/signed_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module signed_divider
  import coord_immediate_cmd_a_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // request
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  // result
  output logic done,
  output logic [31:0] quotient,
  output logic [31:0] remainder
);
  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
    logic q_neg;
    logic r_neg;
    logic done;
    logic [31:0] q_out;
    logic [31:0] r_out;
  } div_state_type;

  div_state_type s_reg, s_next;
  logic [32:0] trial;

  // restoring division on magnitudes, signs fixed at the end (truncating)
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    trial = {s_reg.rem[31:0], s_reg.quo[31]} - {1'b0, s_reg.den};
    if (start && !s_reg.busy) begin
      s_next.busy = 1'b1;
      s_next.cnt = DIV_STEPS;
      s_next.rem = '0;
      s_next.quo = dividend[31] ? 32'(-dividend) : dividend;
      s_next.den = divisor[31] ? 32'(-divisor) : divisor;
      s_next.q_neg = dividend[31] ^ divisor[31];
      s_next.r_neg = dividend[31];
    end else if (s_reg.busy) begin
      if (!trial[32]) begin
        s_next.rem = trial;
        s_next.quo = {s_reg.quo[30:0], 1'b1};
      end else begin
        s_next.rem = {s_reg.rem[31:0], s_reg.quo[31]};
        s_next.quo = {s_reg.quo[30:0], 1'b0};
      end
      s_next.cnt = 6'(s_reg.cnt - 6'h01);
      if (s_reg.cnt == 6'h01) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.q_out = s_reg.q_neg ? 32'(-s_next.quo) : s_next.quo;
        s_next.r_out = s_reg.r_neg ? 32'(-s_next.rem[31:0]) : s_next.rem[31:0];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign quotient = s_reg.q_out;
  assign remainder = s_reg.r_out;
endmodule : signed_divider
`default_nettype wire

// *** bench/host_frame_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  // clock
  input wire logic sys_clk,
  // frame bytes toward the device
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // idle line at power up
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
  end
  // sends one nine-byte frame, checksum optionally spoiled
  task automatic send(input logic [7:0] adr, op, ty, mo, input logic [31:0] v,
                      input logic bad);
    logic [7:0] b [9];
    b = '{adr, op, ty, mo, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
    b[8] = b[8] ^ {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_byte <= b[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b[8]; // no stale byte after the frame
  endtask : send
endmodule : host_frame_model
`default_nettype wire

// *** bench/coord_immediate_cmd_a_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module coord_immediate_cmd_a_checker
  import coord_immediate_cmd_a_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // program command
  input wire logic prog_valid,
  input wire logic [7:0] prog_opcode,
  input wire logic [7:0] prog_type,
  input wire logic [7:0] prog_motor,
  // reply and results
  input wire logic busy,
  input wire logic reply_valid,
  input wire logic reply_prog,
  input wire logic [7:0] reply_status,
  input wire logic [7:0] reply_opcode,
  input wire logic [31:0] reply_value,
  input wire logic param_wr,
  input wire logic [1:0] param_motor,
  input wire logic [7:0] param_num,
  input wire logic [31:0] param_data,
  input wire logic [31:0] accu_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // program command taken while idle
  logic take;
  assign take = prog_valid && !busy;
  AST_REPLY_PULSE: assert property (reply_valid |=> !reply_valid)
    else $error("reply strobe too long");
  AST_PARAM_REPLY: assert property (
    param_wr |-> reply_valid && reply_opcode == OP_ACCU_AXIS && param_data == accu_out)
    else $error("param write without matching reply");
  AST_PARAM_TIMING: assert property (
    take && prog_opcode == OP_ACCU_AXIS && prog_motor <= MOTOR_MAX
    |-> ##2 param_wr && {6'h00, param_motor} == $past(prog_motor, 2)
    && param_num == $past(prog_type, 2))
    else $error("param write missing or wrong target");
  AST_LOAD_KEEPS_ACCU: assert property (
    take && prog_opcode == OP_X_IMMEDIATE_CMD_A && prog_type == IMMEDIATE_CMD_A_LOAD
    |-> ##2 reply_valid && accu_out == $past(accu_out, 2))
    else $error("load changed accumulator");
  AST_IMMEDIATE_CMD_A_OK: assert property (
    take && prog_opcode == OP_X_IMMEDIATE_CMD_A && prog_type >= IMMEDIATE_CMD_A_AND && prog_type <= IMMEDIATE_CMD_A_SWAP
    |-> ##2 reply_valid && reply_prog && reply_status == STATUS_OK)
    else $error("immediate_cmd_a reply wrong");
  AST_DIV_BOUND: assert property (
    take && prog_opcode == OP_X_IMMEDIATE_CMD_A && prog_type == IMMEDIATE_CMD_A_DIV
    |=> busy ##[1:40] reply_valid && reply_opcode == OP_X_IMMEDIATE_CMD_A)
    else $error("divide reply late");
  AST_RESTORE_ALL: assert property (
    take && prog_opcode == OP_COORD_READ && prog_type == 8'h00 && prog_motor == RESTORE_MOTOR
    |=> busy [*8] ##[1:90] reply_valid && reply_status == STATUS_OK)
    else $error("bulk restore wrong");
  AST_HOST_READ_ACCU: assert property (
    reply_valid && !reply_prog && reply_opcode == OP_COORD_READ |-> $stable(accu_out))
    else $error("host read changed accumulator");
  AST_PROG_READ_LOADS: assert property (
    take && prog_opcode == OP_COORD_READ && prog_type <= COORD_MAX && prog_motor <= MOTOR_MAX
    |-> ##2 reply_valid && accu_out == reply_value)
    else $error("program read did not load accumulator");
  AST_BAD_MOTOR: assert property (
    take && prog_opcode == OP_POS_CAPTURE && prog_motor > MOTOR_MAX && prog_type <= COORD_MAX
    |-> ##2 reply_valid && reply_status == STATUS_BAD_VALUE)
    else $error("bad motor not refused");
endmodule : coord_immediate_cmd_a_checker
bind coordinate_store_and_accu_immediate_cmd_a coord_immediate_cmd_a_checker u_checker (
  .sys_clk(sys_clk), .nrst(nrst), .prog_valid(prog_valid), .prog_opcode(prog_opcode),
  .prog_type(prog_type), .prog_motor(prog_motor), .busy(busy), .reply_valid(reply_valid),
  .reply_prog(reply_prog), .reply_status(reply_status), .reply_opcode(reply_opcode),
  .reply_value(reply_value), .param_wr(param_wr), .param_motor(param_motor),
  .param_num(param_num), .param_data(param_data), .accu_out(accu_out)
);
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import coord_immediate_cmd_a_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic prog_valid = 1'b0;
  logic coord_nv_mode = 1'b0;
  logic [7:0] prog_opcode = 8'h00, prog_type = 8'h00, prog_motor = 8'h00, module_addr = 8'h01;
  logic [31:0] prog_value = 32'h0000_0000;
  logic [NUM_MOTORS-1:0][31:0] actual_pos = '0;
  logic rx_valid, busy, reply_valid, reply_prog, param_wr;
  logic [7:0] rx_byte, reply_status, reply_opcode, param_num;
  logic [1:0] param_motor;
  logic [31:0] reply_value, param_data, accu_out, acc, x;
  int err_total = 0;
  int compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  coordinate_store_and_accu_immediate_cmd_a dut (.sys_clk(sys_clk), .nrst(nrst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .module_addr(module_addr), .prog_valid(prog_valid),
    .prog_opcode(prog_opcode), .prog_type(prog_type), .prog_motor(prog_motor),
    .prog_value(prog_value), .coord_nv_mode(coord_nv_mode), .actual_pos(actual_pos),
    .busy(busy), .reply_valid(reply_valid), .reply_prog(reply_prog),
    .reply_status(reply_status), .reply_opcode(reply_opcode), .reply_value(reply_value),
    .param_wr(param_wr), .param_motor(param_motor), .param_num(param_num),
    .param_data(param_data), .accu_out(accu_out));
  host_frame_model host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait for the reply strobe, current cycle included (checksum reply is early)
  task automatic wait_reply(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      #1;
      seen = (reply_valid === 1'b1);
      if (!seen) @(posedge sys_clk);
    end
  endtask : wait_reply
  // host frame and reply
  task automatic host_cmd(input logic [7:0] op, ty, mo, input logic bad, input logic [7:0] st,
                          input logic [31:0] val, input logic chk);
    logic seen;
    host.send(8'h01, op, ty, mo, 32'h0000_0000, bad);
    wait_reply(200, seen);
    check({31'h0, seen}, 32'h1);
    check({24'h0, reply_status}, {24'h0, st});
    if (chk) check(reply_value, val);
  endtask : host_cmd
  // program command and reply
  task automatic prog_cmd(input logic [7:0] op, ty, mo, input logic [7:0] st);
    logic seen;
    @(posedge sys_clk);
    prog_valid <= 1'b1;
    prog_opcode <= op;
    prog_type <= ty;
    prog_motor <= mo;
    @(posedge sys_clk);
    prog_valid <= 1'b0;
    wait_reply(200, seen);
    check({31'h0, seen & reply_prog}, 32'h1);
    check({24'h0, reply_status}, {24'h0, st});
  endtask : prog_cmd
  // storage mode and motor 0 position
  task automatic set_in(input logic nv, input logic [31:0] p0);
    @(posedge sys_clk);
    coord_nv_mode <= nv;
    actual_pos[0] <= p0;
  endtask : set_in
  // one x register calculation against a reference
  task automatic sc_immediate_cmd_a(input int t);
    logic [7:0] st;
    st = STATUS_OK;
    case (t)
      0: acc = acc + x;
      1: acc = acc - x;
      2: acc = acc * x;
      3: if (x == 0) st = STATUS_BAD_VALUE; else acc = $signed(acc) / $signed(x);
      4: if (x == 0) st = STATUS_BAD_VALUE; else acc = $signed(acc) % $signed(x);
      5: acc = acc & x;
      6: acc = acc | x;
      7: acc = acc ^ x;
      8: x = ~x;
      9: x = acc;
      default: {acc, x} = {x, acc};
    endcase
    prog_cmd(OP_X_IMMEDIATE_CMD_A, 8'(t), 8'h00, st);
    check(accu_out, acc);
  endtask : sc_immediate_cmd_a
  // verdict
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
  // capture, program read, accumulator store and x register arithmetic
  task automatic sc_table;
    set_in(1'b0, 32'hFFFF_FF9C);
    host_cmd(OP_POS_CAPTURE, 8'h01, 8'h00, 1'b0, STATUS_OK, 32'hFFFF_FF9C, 1'b1);
    prog_cmd(OP_COORD_READ, 8'h01, 8'h00, STATUS_OK);
    prog_cmd(OP_X_IMMEDIATE_CMD_A, IMMEDIATE_CMD_A_LOAD, 8'h00, STATUS_OK);
    set_in(1'b0, 32'h0000_0007);
    host_cmd(OP_POS_CAPTURE, 8'h14, 8'h00, 1'b0, STATUS_OK, 32'h0000_0007, 1'b1);
    prog_cmd(OP_COORD_READ, 8'h14, 8'h00, STATUS_OK);
    acc = 32'h0000_0007;
    x = 32'hFFFF_FF9C;
    prog_cmd(OP_ACCU_COORD, 8'h05, 8'h01, STATUS_OK);
    host_cmd(OP_COORD_READ, 8'h05, 8'h01, 1'b0, STATUS_OK, acc, 1'b1);
    check(accu_out, acc);
    prog_cmd(OP_ACCU_AXIS, 8'h07, 8'h02, STATUS_OK);
    check({21'h0, param_wr, param_motor, param_num}, 32'h0000_0607);
    check(param_data, acc);
    for (int i = 0; i < 22; i++) sc_immediate_cmd_a((i * 4) % 11);
    // accumulator is zero here: load it into x, then divide by zero is refused
    sc_immediate_cmd_a(9);
    sc_immediate_cmd_a(3);
    // capture from the last motor into the last entry
    @(posedge sys_clk);
    actual_pos[3] <= 32'h8000_0001;
    host_cmd(OP_POS_CAPTURE, 8'h14, 8'h03, 1'b0, STATUS_OK, 32'h8000_0001, 1'b1);
    host_cmd(OP_COORD_READ, 8'h14, 8'h03, 1'b0, STATUS_OK, 32'h8000_0001, 1'b1);
  endtask : sc_table
  // refusals leave the table alone
  task automatic sc_refuse;
    logic seen;
    host_cmd(OP_POS_CAPTURE, 8'h01, 8'h00, 1'b1, STATUS_BAD_CSUM, 32'h0, 1'b0);
    host_cmd(OP_POS_CAPTURE, 8'h15, 8'h00, 1'b0, STATUS_BAD_TYPE, 32'h0, 1'b0);
    host_cmd(OP_POS_CAPTURE, 8'h01, 8'h04, 1'b0, STATUS_BAD_VALUE, 32'h0, 1'b0);
    host_cmd(OP_COORD_READ, 8'h15, RESTORE_MOTOR, 1'b0, STATUS_BAD_TYPE, 32'h0, 1'b0);
    host_cmd(8'h30, 8'h00, 8'h00, 1'b0, STATUS_BAD_CMD, 32'h0, 1'b0);
    host_cmd(OP_X_IMMEDIATE_CMD_A, 8'h0B, 8'h00, 1'b0, STATUS_BAD_TYPE, 32'h0, 1'b0);
    prog_cmd(OP_POS_CAPTURE, 8'h01, 8'h04, STATUS_BAD_VALUE);
    host.send(8'h02, OP_POS_CAPTURE, 8'h01, 8'h00, 32'h0, 1'b0);
    wait_reply(20, seen);
    check({31'h0, seen}, 32'h0);
    host_cmd(OP_COORD_READ, 8'h01, 8'h00, 1'b0, STATUS_OK, 32'hFFFF_FF9C, 1'b1);
  endtask : sc_refuse
  // nonvolatile copies and restores
  task automatic sc_nv;
    set_in(1'b1, 32'h0000_1234);
    host_cmd(OP_POS_CAPTURE, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_1234, 1'b1);
    set_in(1'b1, 32'h0000_0ABC);
    host_cmd(OP_POS_CAPTURE, 8'h00, 8'h00, 1'b0, STATUS_OK, 32'h0000_0ABC, 1'b1);
    set_in(1'b0, 32'h0000_5555);
    host_cmd(OP_POS_CAPTURE, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_5555, 1'b1);
    host_cmd(OP_COORD_READ, 8'h02, RESTORE_MOTOR, 1'b0, STATUS_OK, 32'h0, 1'b0);
    host_cmd(OP_COORD_READ, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_1234, 1'b1);
    host_cmd(OP_POS_CAPTURE, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_5555, 1'b1);
    prog_cmd(OP_COORD_READ, 8'h00, RESTORE_MOTOR, STATUS_OK);
    host_cmd(OP_COORD_READ, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_1234, 1'b1);
    host_cmd(OP_COORD_READ, 8'h00, 8'h00, 1'b0, STATUS_OK, 32'h0000_0ABC, 1'b1);
  endtask : sc_nv
  // reset in mid-run with nonvolatile storage selected reloads entries 1..20
  task automatic sc_boot;
    int n;
    n = 0;
    host_cmd(OP_POS_CAPTURE, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_5555, 1'b1);
    @(posedge sys_clk);
    nrst <= 1'b0;
    coord_nv_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    while (busy === 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    check(32'(n), 32'(NUM_MOTORS * int'(COORD_MAX)));
    check(accu_out, WORD_RESET);
    host_cmd(OP_COORD_READ, 8'h02, 8'h00, 1'b0, STATUS_OK, 32'h0000_1234, 1'b1);
    host_cmd(OP_COORD_READ, 8'h00, 8'h00, 1'b0, STATUS_OK, 32'h0000_0ABC, 1'b1);
  endtask : sc_boot
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sc_table();
    sc_refuse();
    sc_nv();
    sc_boot();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
